// [rtl/bcp_pkg.sv]
package bcp_pkg;

   // Register map on the plain software port (byte addresses, one word each).
   localparam logic [7:0] ADDR_CTRL = 8'h00;
   localparam logic [7:0] ADDR_STATUS = 8'h04;
   localparam logic [7:0] ADDR_WAITS = 8'h08;

   // Field positions.
   localparam int CTRL_IRQ_EN_BIT = 0;
   localparam int ST_HOLD_BIT = 0;
   localparam int ST_TEST_IDLE_BIT = 1;
   localparam int ST_MIN_MODE_BIT = 2;
   localparam int ST_NMI_PEND_BIT = 3;
   localparam int ST_IN_RESET_BIT = 4;
   localparam int ST_STATE_LSB = 8;

   // Values after reset.
   localparam logic CTRL_IRQ_EN_RST = 1'b0;
   localparam logic [15:0] WAITS_RST = 16'h0000;
   localparam logic [31:0] RDATA_RST = 32'h0000_0000;

   // Timing: system clocks per bus state and the point inside t2 where the
   // multiplexed bus has finished floating.
   localparam logic [1:0] PHASE_LAST = 2'h2;
   localparam logic [1:0] PHASE_FLOAT_DONE = 2'h1;

   // Vector type of the non-maskable interrupt.
   localparam logic [7:0] NMI_VECTOR_TYPE = 8'h02;

   // Bus states.
   typedef enum logic [2:0] {
      BS_TI,
      BS_T1,
      BS_T2,
      BS_T3,
      BS_TW,
      BS_T4,
      BS_HOLD
   } bcp_state_t;

   // A bus cycle request from the execution unit.
   typedef struct packed {
      logic is_read;
      logic is_mem;
   } bcp_req_t;

   // Register port request.
   typedef struct packed {
      logic [7:0] addr;
      logic [31:0] wdata;
      logic wr;
      logic rd;
   } bcp_reg_req_t;

endpackage : bcp_pkg

// [rtl/bcp_bus_ctrl.sv]
// Overview of operation
// RULE_01: Read strobe is low in t2, t3 and wait states of a read, else high.
// RULE_02: At the start of t2 read strobe stays high until the bus has floated.
// RULE_03: During bus grant the read strobe floats, pulled to logic one.
// RULE_04: Each read is memory or I/O, chosen by the status line.
// RULE_05: A transfer completes only once the addressed device asserts ready.
// RULE_06: The outside delivers ready already synchronous, meeting setup and hold.
// RULE_07: Ready low at end of t3 or a wait state adds another wait state.
// RULE_08: Maskable request sampled in last instruction cycle starts acknowledge.
// RULE_09: Maskable request is ignored while the interrupt enable flag is clear.
// RULE_10: Maskable request passes an internal synchronizer before use.
// RULE_11: Wait-for-test continues when synchronized test is low, otherwise idles.
// RULE_12: Non-maskable rising edge starts a type 2 interrupt.
// RULE_13: Synchronized reset abandons activity at once; restart on its release.
// RULE_14: Reset source holds reset high at least four clocks after rising.
// RULE_15: Clock source supplies an asymmetric 33 percent duty clock; the testbench clock is symmetric, toggling every 20 ns.
// RULE_16: Mode-select level chooses minimum or maximum mode of control pins.
// RULE_17: In minimum mode the status line is high for memory, low for I/O.
// RULE_18: Bus grant raises hold grant and floats bus and control lines together.
//
// The placing of the registers and the strobed register port were left to the implementer.
`timescale 1ns/100ps
`default_nettype none

module bcp_bus_ctrl (
   input wire logic i_clk_sys,
   input wire logic i_arst_n,
   // Software register port.
   input wire bcp_pkg::bcp_reg_req_t i_reg,
   output logic [31:0] o_reg_rdata,
   // Execution unit side.
   input wire logic i_cyc_req,
   input wire bcp_pkg::bcp_req_t i_cyc,
   input wire logic i_instr_last,
   input wire logic i_wait_test_exec,
   output logic o_cyc_done,
   output logic o_irq_ack_start,
   output logic o_nmi_start,
   output logic [7:0] o_vector_type,
   output logic o_test_continue,
   output logic o_test_idle,
   output logic o_core_run,
   // Pins.
   input wire logic i_ready,
   input wire logic i_maskable_irq,
   input wire logic i_nmi,
   input wire logic i_test_n,
   input wire logic i_reset,
   input wire logic i_mode_select_min_max,
   input wire logic i_hold,
   output logic o_rd_n,
   output logic o_rd_oe_n,
   output logic o_mem_io,
   output logic o_mem_io_oe_n,
   output logic o_status_line_two_n,
   output logic o_hold_grant,
   output logic o_bus_float,
   output logic [2:0] o_bus_state
);

   // Sequencer state and the cycle kind latched when a cycle starts.
   bcp_pkg::bcp_state_t state;
   bcp_pkg::bcp_req_t cur;
   // Position inside the current bus state and the one-in-three bus state enable.
   logic [1:0] phase;
   logic tick;
   // Synchronizer stages; only the second stage is read by the logic, plus the third non-maskable stage for its edge.
   logic rst_s1, rst_s2;
   logic irq_s1, irq_s2;
   logic nmi_s1, nmi_s2, nmi_d;
   logic test_s1, test_s2;
   // Captured mode strap, software enable flag and pending edge request.
   logic min_mode;
   logic irq_en;
   logic nmi_pend;
   // Wait states of the running cycle and of the last finished one.
   logic [15:0] wait_cnt;
   logic [15:0] last_waits;
   // Read strobe value for the next clock.
   logic next_rd_n;

   // Two-stage synchronizers for reset, interrupt and test inputs.
   // The reset stages come up asserted, so the block stays quiet until the pin release has passed.
   // The edge stage resets low like the idle pin, so no false edge follows reset.
   always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
      if (!i_arst_n) begin
         rst_s1 <= 1'b1;
         rst_s2 <= 1'b1;
         irq_s1 <= 1'b0;
         irq_s2 <= 1'b0;
         nmi_s1 <= 1'b0;
         nmi_s2 <= 1'b0;
         nmi_d <= 1'b0;
         test_s1 <= 1'b1;
         test_s2 <= 1'b1;
      end else begin
         rst_s1 <= i_reset;
         rst_s2 <= rst_s1; // RULE_13
         irq_s1 <= i_maskable_irq;
         irq_s2 <= irq_s1; // RULE_10
         nmi_s1 <= i_nmi;
         nmi_s2 <= nmi_s1;
         nmi_d <= nmi_s2;
         test_s1 <= i_test_n;
         test_s2 <= test_s1;
      end
   end

   // Bus state divider: one tick every three system clocks.
   // It restarts while reset is held, so the first bus state after release is a full one.
   always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
      if (!i_arst_n) begin
         phase <= 2'h0;
      end else if (rst_s2 || phase == bcp_pkg::PHASE_LAST) begin
         phase <= 2'h0;
      end else begin
         phase <= phase + 2'h1;
      end
   end

   // Every state decision except the reset return to idle is taken on the last clock of a bus state.
   assign tick = (phase == bcp_pkg::PHASE_LAST);

   // Mode strap is caught while reset is held and kept afterwards.
   always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
      if (!i_arst_n) begin
         min_mode <= 1'b1;
      end else if (rst_s2) begin
         min_mode <= i_mode_select_min_max; // RULE_16
      end
   end

   // Bus state sequencer.
   always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
      if (!i_arst_n) begin
         state <= bcp_pkg::BS_TI;
         cur <= '0;
      end else if (rst_s2) begin
         state <= bcp_pkg::BS_TI; // RULE_13
      end else if (tick) begin
         case (state)
            bcp_pkg::BS_TI: begin
               // A hold request takes priority over a new bus cycle.
               if (i_hold) begin
                  state <= bcp_pkg::BS_HOLD; // RULE_18
               end else if (i_cyc_req) begin
                  state <= bcp_pkg::BS_T1;
                  cur <= i_cyc;
               end
            end
            bcp_pkg::BS_T1: begin
               state <= bcp_pkg::BS_T2;
            end
            bcp_pkg::BS_T2: begin
               state <= bcp_pkg::BS_T3;
            end
            bcp_pkg::BS_T3, bcp_pkg::BS_TW: begin
               // Ready is used as sampled; the source keeps setup and hold.
               if (i_ready) begin // RULE_06
                  state <= bcp_pkg::BS_T4; // RULE_05
               end else begin
                  state <= bcp_pkg::BS_TW; // RULE_07
               end
            end
            bcp_pkg::BS_T4: begin
               // The bus may be handed over straight from t4, with no idle state.
               state <= i_hold ? bcp_pkg::BS_HOLD : bcp_pkg::BS_TI; // RULE_18
            end
            bcp_pkg::BS_HOLD: begin
               // The bus is taken back at the first tick that finds the request gone.
               if (!i_hold) begin
                  state <= bcp_pkg::BS_TI;
               end
            end
            default: begin
               state <= bcp_pkg::BS_TI;
            end
         endcase
      end
   end

   // Read strobe value: low from the float point of t2 through t3 and waits.
   // The strobe is registered and lags the state by one clock, so it stays high for
   // the first two clocks of t2, the time the multiplexed bus needs to float.
   always_comb begin
      next_rd_n = 1'b1;
      if (!rst_s2 && cur.is_read) begin
         case (state)
            bcp_pkg::BS_T2: begin
               next_rd_n = (phase < bcp_pkg::PHASE_FLOAT_DONE); // RULE_02
            end
            bcp_pkg::BS_T3, bcp_pkg::BS_TW: begin
               next_rd_n = 1'b0; // RULE_01
            end
            default: begin
               next_rd_n = 1'b1;
            end
         endcase
      end
   end

   // Pin drivers; floated lines show a pulled-up one with enable high.
   // Every pin is registered so that no decoding glitch reaches the bus.
   always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
      if (!i_arst_n) begin
         o_rd_n <= 1'b1;
         o_rd_oe_n <= 1'b0;
         o_mem_io <= 1'b1;
         o_mem_io_oe_n <= 1'b0;
         o_status_line_two_n <= 1'b1;
         o_hold_grant <= 1'b0;
         o_bus_float <= 1'b0;
         o_bus_state <= 3'h0;
      end else begin
         o_bus_state <= state;
         if (state == bcp_pkg::BS_HOLD) begin
            o_hold_grant <= 1'b1; // RULE_18
            o_bus_float <= 1'b1; // RULE_18
            o_rd_n <= 1'b1; // RULE_03
            o_rd_oe_n <= 1'b1; // RULE_03
            o_mem_io <= 1'b1;
            o_mem_io_oe_n <= 1'b1;
            o_status_line_two_n <= 1'b1;
         end else begin
            o_hold_grant <= 1'b0;
            o_bus_float <= 1'b0;
            o_rd_n <= next_rd_n;
            o_rd_oe_n <= 1'b0;
            o_mem_io_oe_n <= !min_mode; // RULE_16
            // The status line marks each read as memory or I/O.
            // In maximum mode the memory line floats and status line two carries the kind.
            o_mem_io <= min_mode ? cur.is_mem : 1'b1; // RULE_17 RULE_04
            o_status_line_two_n <= min_mode ? 1'b1 : cur.is_mem; // RULE_04
         end
      end
   end

   // Transfer completion and wait-state count.
   // The counter clears on every completion, so one cycle's count never leaks into the next.
   always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
      if (!i_arst_n) begin
         o_cyc_done <= 1'b0;
         wait_cnt <= bcp_pkg::WAITS_RST;
         last_waits <= bcp_pkg::WAITS_RST;
      end else begin
         o_cyc_done <= 1'b0;
         if (rst_s2) begin
            wait_cnt <= bcp_pkg::WAITS_RST;
         end else if (tick && (state == bcp_pkg::BS_T3 || state == bcp_pkg::BS_TW)) begin
            if (i_ready) begin
               o_cyc_done <= 1'b1; // RULE_05
               last_waits <= wait_cnt;
               wait_cnt <= bcp_pkg::WAITS_RST;
            end else begin
               wait_cnt <= wait_cnt + 16'h0001; // RULE_07
            end
         end
      end
   end

   // Interrupt decisions at the last cycle of each instruction.
   // The non-maskable request is served first when both are waiting.
   always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
      if (!i_arst_n) begin
         nmi_pend <= 1'b0;
         o_nmi_start <= 1'b0;
         o_irq_ack_start <= 1'b0;
         o_vector_type <= 8'h00;
      end else begin
         o_nmi_start <= 1'b0;
         o_irq_ack_start <= 1'b0;
         if (rst_s2) begin
            nmi_pend <= 1'b0;
         end else begin
            if (i_instr_last && nmi_pend) begin
               o_nmi_start <= 1'b1; // RULE_12
               o_vector_type <= bcp_pkg::NMI_VECTOR_TYPE; // RULE_12
               nmi_pend <= 1'b0;
            end else if (i_instr_last && irq_s2 && irq_en) begin // RULE_08 RULE_09
               o_irq_ack_start <= 1'b1; // RULE_08
            end
            // A new edge wins over the clear in the same cycle.
            if (nmi_s2 && !nmi_d) begin
               nmi_pend <= 1'b1; // RULE_12
            end
         end
      end
   end

   // Wait-for-test handling and run indication.
   // Both test outputs stay low outside the wait-for-test instruction.
   always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
      if (!i_arst_n) begin
         o_test_continue <= 1'b0;
         o_test_idle <= 1'b0;
         o_core_run <= 1'b0;
      end else begin
         o_core_run <= !rst_s2; // RULE_13
         o_test_continue <= !rst_s2 && i_wait_test_exec && !test_s2; // RULE_11
         o_test_idle <= !rst_s2 && i_wait_test_exec && test_s2; // RULE_11
      end
   end

   // Control register: interrupt enable flag.
   // Reset clears the flag, so maskable interrupts stay off until software sets it again.
   always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
      if (!i_arst_n) begin
         irq_en <= bcp_pkg::CTRL_IRQ_EN_RST;
      end else if (rst_s2) begin
         irq_en <= bcp_pkg::CTRL_IRQ_EN_RST;
      end else if (i_reg.wr && i_reg.addr == bcp_pkg::ADDR_CTRL) begin
         irq_en <= i_reg.wdata[bcp_pkg::CTRL_IRQ_EN_BIT]; // RULE_09
      end
   end

   // Read data stands in the cycle after the read strobe only.
   // Unmapped addresses read as zero, and writes to them are ignored.
   always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
      if (!i_arst_n) begin
         o_reg_rdata <= bcp_pkg::RDATA_RST;
      end else begin
         o_reg_rdata <= bcp_pkg::RDATA_RST;
         if (i_reg.rd) begin
            case (i_reg.addr)
               bcp_pkg::ADDR_CTRL: begin
                  o_reg_rdata[bcp_pkg::CTRL_IRQ_EN_BIT] <= irq_en;
               end
               bcp_pkg::ADDR_STATUS: begin
                  o_reg_rdata[bcp_pkg::ST_HOLD_BIT] <= (state == bcp_pkg::BS_HOLD);
                  o_reg_rdata[bcp_pkg::ST_TEST_IDLE_BIT] <= o_test_idle;
                  o_reg_rdata[bcp_pkg::ST_MIN_MODE_BIT] <= min_mode;
                  o_reg_rdata[bcp_pkg::ST_NMI_PEND_BIT] <= nmi_pend;
                  o_reg_rdata[bcp_pkg::ST_IN_RESET_BIT] <= rst_s2;
                  o_reg_rdata[bcp_pkg::ST_STATE_LSB +: 3] <= state;
               end
               bcp_pkg::ADDR_WAITS: begin
                  o_reg_rdata[15:0] <= last_waits;
               end
               default: begin
                  o_reg_rdata <= bcp_pkg::RDATA_RST;
               end
            endcase
         end
      end
   end

endmodule : bcp_bus_ctrl

`default_nettype wire

// [test/bcp_mem_model.sv]
`timescale 1ns/100ps
`default_nettype none
module bcp_mem_model (
   input wire logic i_clk_sys,
   input wire logic i_arst_n,
   input wire logic [2:0] i_bus_state,
   input wire logic [1:0] i_waits,
   output logic o_ready
);
   logic [3:0] cnt;
   logic tog;
   logic in_xfer;
   assign in_xfer = (i_bus_state == 3'h3) || (i_bus_state == 3'h4);
   // Counts clocks in t3 and wait states; the toggle makes ready useless elsewhere.
   always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
      if (!i_arst_n) begin
         cnt <= 4'h0;
         tog <= 1'b0;
      end else begin
         cnt <= in_xfer ? cnt + 4'h1 : 4'h0;
         tog <= ~tog;
      end
   end
   // Ready is given synchronously once the chosen wait states have passed.
   assign o_ready = in_xfer ? (cnt >= 4'(3 * i_waits)) : tog;
endmodule : bcp_mem_model
`default_nettype wire

// [test/bcp_bus_ctrl_assertions.sv]
`timescale 1ns/100ps
`default_nettype none
module bcp_bus_ctrl_chk (
   input wire logic i_clk_sys,
   input wire logic i_arst_n,
   input wire logic i_ready,
   input wire logic i_instr_last,
   input wire logic i_reset,
   input wire logic o_rd_n,
   input wire logic o_rd_oe_n,
   input wire logic o_hold_grant,
   input wire logic o_bus_float,
   input wire logic o_cyc_done,
   input wire logic [2:0] o_bus_state,
   input wire logic o_nmi_start,
   input wire logic [7:0] o_vector_type,
   input wire logic o_irq_ack_start,
   input wire logic o_test_continue,
   input wire logic o_test_idle,
   input wire logic o_core_run
);
   default clocking cb @(posedge i_clk_sys);
   endclocking
   default disable iff (!i_arst_n);
   // Strobe and handshake relations, all on the system clock.
   rd_low_states_a: assert property (!o_rd_n |-> $past(o_bus_state) inside {3'h2, 3'h3, 3'h4})
      else $error("read strobe low outside t2 t3 tw");
   rd_float_gap_a: assert property ((o_bus_state == 3'h2 && $past(o_bus_state) == 3'h1) |-> o_rd_n)
      else $error("read strobe low before bus floated");
   rd_hold_float_a: assert property (o_hold_grant |-> o_rd_oe_n && o_rd_n)
      else $error("read strobe driven in hold");
   done_needs_ready_a: assert property (o_cyc_done |-> $past(i_ready) && $past(o_bus_state) inside {3'h3, 3'h4})
      else $error("transfer done without ready");
   wait_insert_a: assert property ((o_bus_state == 3'h4 && $past(o_bus_state) == 3'h3) |-> !$past(i_ready, 2))
      else $error("wait state with ready high");
   irq_at_last_a: assert property (o_irq_ack_start |-> $past(i_instr_last))
      else $error("acknowledge outside last instruction cycle");
   nmi_vector_a: assert property (o_nmi_start |-> ##[0:1] (o_vector_type == 8'h02))
      else $error("nmi vector type wrong");
   test_exclusive_a: assert property (!(o_test_continue && o_test_idle))
      else $error("test continue and idle together");
   reset_stops_a: assert property (i_reset [*4] |=> !o_core_run)
      else $error("core runs during reset");
   grant_float_a: assert property (o_hold_grant == o_bus_float)
      else $error("grant and float differ");
endmodule : bcp_bus_ctrl_chk
bind bcp_bus_ctrl bcp_bus_ctrl_chk u_bcp_bus_ctrl_chk (.i_clk_sys(i_clk_sys), .i_arst_n(i_arst_n),
   .i_ready(i_ready), .i_instr_last(i_instr_last), .i_reset(i_reset), .o_rd_n(o_rd_n),
   .o_rd_oe_n(o_rd_oe_n), .o_hold_grant(o_hold_grant), .o_bus_float(o_bus_float),
   .o_cyc_done(o_cyc_done), .o_bus_state(o_bus_state), .o_nmi_start(o_nmi_start),
   .o_vector_type(o_vector_type), .o_irq_ack_start(o_irq_ack_start),
   .o_test_continue(o_test_continue), .o_test_idle(o_test_idle), .o_core_run(o_core_run));
`default_nettype wire

// [test/bcp_bus_ctrl_tb.sv]
`timescale 1ns/100ps
`default_nettype none
module bcp_bus_ctrl_tb;
   logic clk, arst_n, cyc_req, last, wt, ready, irq, nmi, test_n, rst, mode, hold;
   logic done, iack, nmis, tcont, tidle, run, rd_n, rd_oe, mio, mio_oe, s2_n, grant, flt;
   logic [31:0] rdata;
   logic [7:0] vec;
   logic [2:0] st;
   logic [1:0] waits;
   bcp_pkg::bcp_reg_req_t rq;
   bcp_pkg::bcp_req_t cyc;
   int failures, cmp_count;
   bcp_bus_ctrl u_bcp_bus_ctrl (.i_clk_sys(clk), .i_arst_n(arst_n), .i_reg(rq),
      .o_reg_rdata(rdata), .i_cyc_req(cyc_req), .i_cyc(cyc), .i_instr_last(last),
      .i_wait_test_exec(wt), .o_cyc_done(done), .o_irq_ack_start(iack), .o_nmi_start(nmis),
      .o_vector_type(vec), .o_test_continue(tcont), .o_test_idle(tidle), .o_core_run(run),
      .i_ready(ready), .i_maskable_irq(irq), .i_nmi(nmi), .i_test_n(test_n), .i_reset(rst),
      .i_mode_select_min_max(mode), .i_hold(hold), .o_rd_n(rd_n), .o_rd_oe_n(rd_oe),
      .o_mem_io(mio), .o_mem_io_oe_n(mio_oe), .o_status_line_two_n(s2_n),
      .o_hold_grant(grant), .o_bus_float(flt), .o_bus_state(st));
   bcp_mem_model u_bcp_mem_model (.i_clk_sys(clk), .i_arst_n(arst_n), .i_bus_state(st),
      .i_waits(waits), .o_ready(ready));
   // The system clock; the block runs its bus states on a one-in-three enable of it.
   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end
   task automatic chk(input logic ok, input string m);
      cmp_count++;
      if (ok !== 1'b1) begin
         failures++;
         $display("BAD %0t %s", $time, m);
      end
   endtask : chk
   task automatic report_and_stop;
      if (failures == 0 && cmp_count > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask : report_and_stop
   task automatic reg_wr(input logic [7:0] a, input logic [31:0] v);
      rq.addr <= a;
      rq.wdata <= v;
      rq.wr <= 1'b1;
      @(posedge clk);
      rq.wr <= 1'b0;
   endtask : reg_wr
   // Read data stand only in the cycle after the strobe.
   task automatic reg_rd(input logic [7:0] a, input logic [31:0] e);
      rq.addr <= a;
      rq.rd <= 1'b1;
      @(posedge clk);
      rq.rd <= 1'b0;
      @(posedge clk);
      chk(rdata === e, "register read");
   endtask : reg_rd
   task automatic wait_sig(ref logic s, input logic v);
      int n;
      n = 0;
      while (s !== v && n < 60) begin
         @(posedge clk);
         n++;
      end
      chk(s === v, "signal never came");
   endtask : wait_sig
   // Expected clocks with the read strobe low: float gap, t3, waits, lag into t4.
   function automatic int exp_lo(input logic [1:0] w);
      return 6 + 3 * int'(w);
   endfunction : exp_lo
   task automatic run_cyc(input logic rk, input logic mk, input logic [1:0] w);
      int n, lo;
      n = 0;
      lo = 0;
      waits <= w;
      cyc <= '{is_read: rk, is_mem: mk};
      cyc_req <= 1'b1;
      while (done !== 1'b1 && n < 100) begin
         @(posedge clk);
         n++;
         if (rd_n === 1'b0) begin
            lo++;
            chk((mode ? mio : s2_n) === mk, "status line");
            chk(mio_oe === !mode && rd_oe === 1'b0, "status drive");
         end
      end
      cyc_req <= 1'b0;
      chk(n >= 9 + 3 * int'(w) && n <= 13 + 3 * int'(w), "cycle length");
      chk(rk ? (lo >= exp_lo(w) - 1 && lo <= exp_lo(w)) : lo == 0, "strobe span");
      repeat (3) @(posedge clk);
      chk(rd_n === 1'b1, "strobe left low");
      reg_rd(bcp_pkg::ADDR_WAITS, {30'h0000_0000, w});
   endtask : run_cyc
   task automatic take_last(output logic a, output logic m);
      last <= 1'b1;
      @(posedge clk);
      last <= 1'b0;
      @(posedge clk);
      a = iack;
      m = nmis;
   endtask : take_last
   task automatic do_reset;
      rst <= 1'b1;
      // The strap alternates so both minimum and maximum mode get exercised.
      mode <= !mode;
      repeat (8) @(posedge clk);
      chk(run === 1'b0, "core runs in reset");
      rst <= 1'b0;
      wait_sig(run, 1'b1);
      reg_rd(bcp_pkg::ADDR_STATUS, {29'h0000_0000, mode, 2'h0});
   endtask : do_reset
   // Watchdog for a hung handshake.
   initial begin
      repeat (20000) @(posedge clk);
      failures++;
      report_and_stop();
   end
   // Main sequence.
   initial begin
      logic a, m;
      {arst_n, cyc_req, last, wt, irq, nmi, test_n, hold, waits} = '0;
      rst = 1'b1;
      mode = 1'b1;
      rq = '0;
      cyc = '0;
      failures = 0;
      cmp_count = 0;
      void'($urandom(60010));
      repeat (16) @(posedge clk);
      arst_n <= 1'b1;
      do_reset();
      reg_rd(bcp_pkg::ADDR_CTRL, 32'h0000_0000);
      reg_wr(8'h0C, 32'hFFFF_FFFF);
      reg_rd(8'h0C, 32'h0000_0000);
      run_cyc(1'b1, 1'b1, 2'h0);
      run_cyc(1'b1, 1'b0, 2'h3);
      for (int i = 0; i < 10; i++) begin
         if (i == 5) begin
            do_reset();
         end
         run_cyc(1'($urandom % 2), 1'($urandom % 2), 2'($urandom % 4));
      end
      irq <= 1'b1;
      repeat (4) @(posedge clk);
      take_last(a, m);
      chk(a === 1'b0, "masked request taken");
      reg_wr(bcp_pkg::ADDR_CTRL, 32'h0000_0001);
      reg_rd(bcp_pkg::ADDR_CTRL, 32'h0000_0001);
      take_last(a, m);
      chk(a === 1'b1, "request not taken");
      irq <= 1'b0;
      nmi <= 1'b1;
      repeat (4) @(posedge clk);
      take_last(a, m);
      chk(m === 1'b1 && vec === 8'h02, "nmi not taken");
      nmi <= 1'b0;
      wt <= 1'b1;
      repeat (5) @(posedge clk);
      chk(tcont === 1'b1 && tidle === 1'b0, "test low");
      test_n <= 1'b1;
      repeat (5) @(posedge clk);
      chk(tidle === 1'b1 && tcont === 1'b0, "test high");
      wt <= 1'b0;
      hold <= 1'b1;
      wait_sig(grant, 1'b1);
      repeat (2) @(posedge clk);
      chk(rd_oe && rd_n && flt && mio_oe, "hold float");
      hold <= 1'b0;
      wait_sig(grant, 1'b0);
      run_cyc(1'b1, 1'b1, 2'h1);
      report_and_stop();
   end
endmodule : bcp_bus_ctrl_tb
`default_nettype wire
